// File: src/sector_mem_defines.svh
`ifndef SECTOR_MEM_DEFINES_SVH
`define SECTOR_MEM_DEFINES_SVH

// ==========================================================
// address layout
`define ADDR_W            9
`define SECTOR_BIT        8
`define GP_SEL_BIT        7
`define GP_WORDS          256
`define GP_INDEX_W        8

// ==========================================================
// special-function offsets inside sector 0
`define OFS_PORT_0        8'h00
`define OFS_POINTER_0     8'h01
`define OFS_PORT_1        8'h02
`define OFS_POINTER_1_LOW 8'h03
`define OFS_POINTER_1_SEC 8'h04
`define OFS_PORT_2        8'h0C
`define OFS_POINTER_2_LOW 8'h0D
`define OFS_POINTER_2_SEC 8'h0E
`define OFS_LAST_LOC      8'h60
`define OFS_LAST_SECTOR   8'h61

// ==========================================================
// reset values
`define POINTER_RESET     8'h00
`define RAM_RESET         8'h00
`define READ_ZERO         8'h00

`endif

// File: src/sector_mem_pkg.sv
`include "sector_mem_defines.svh"

package sector_mem_pkg;

   // ==========================================================
   // request carrier
   typedef enum logic [1:0] {
      op_write,
      op_set_bit,
      op_clear_bit
   } write_op_type;

   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [7:0]         wdata;
      logic               wr;
      logic               rd;
      write_op_type       op;
      logic [2:0]         bit_sel;
   } mem_req_type;

   // resolved physical target of one access
   typedef struct packed {
      logic       sector;
      logic [7:0] loc;
      logic       via_port;
   } target_type;

   // ==========================================================
   // whole state of the block
   typedef struct packed {
      logic [`GP_WORDS-1:0][7:0] ram;
      logic [7:0]                pointer_0;
      logic [7:0]                pointer_1_low;
      logic [7:0]                pointer_1_sector;
      logic [7:0]                pointer_2_low;
      logic [7:0]                pointer_2_sector;
      logic [7:0]                last_loc;
      logic [7:0]                last_sector;
      logic [7:0]                rd_data;
   } state_type;

endpackage : sector_mem_pkg

// File: src/sector_mem.sv
//Behaviour
//RQ1 - no bank register; indirect sector comes only from pointer high byte
//RQ2 - ports 1 and 2: sector from pointer high byte, location from low
//RQ3 - extended direct access carries a 9-bit data address
//RQ4 - extended address: upper bit is sector, lower byte is location
//RQ5 - extended direct access reaches sectors beyond 0 without pointers
//RQ6 - general RAM reads, writes, and single-bit set or clear
//RQ7 - read-only special registers ignore writes
//RQ8 - unimplemented special locations read zero
//RQ9 - port access redirected to location named by its pointer
//RQ10 - port 0 with pointer 0 reaches sector 0 only
//RQ11 - ports 1 and 2 reach every implemented sector
//RQ12 - port locations themselves read zero and ignore writes
//RQ13 - special registers below 80H, general RAM 80H to FFH per sector
//RQ14 - only sector byte bit 0 selects sector; higher bits ignored
`timescale 1ns/10ps
`default_nettype none
`include "sector_mem_defines.svh"

module sector_mem (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire sector_mem_pkg::mem_req_type req,
   output var  logic [7:0]                 rd_data,
   output var  logic [7:0]                 last_loc,
   output var  logic                       last_sector
);
   import sector_mem_pkg::*;

   state_type state_reg;
   state_type state_next;

   // ==========================================================
   // address helpers
   function automatic logic is_port(input logic [7:0] loc);
      is_port = (loc == `OFS_PORT_0) || (loc == `OFS_PORT_1) ||
                (loc == `OFS_PORT_2);
   endfunction : is_port

   function automatic logic [`GP_INDEX_W-1:0] gp_index(
      input logic       sector,
      input logic [7:0] loc
   );
      gp_index = {sector, loc[6:0]}; // [RQ13]
   endfunction : gp_index

   // map a 9-bit request address onto a physical target
   function automatic target_type resolve(
      input state_type          s,
      input logic [`ADDR_W-1:0] addr
   );
      target_type t;
      t.sector   = addr[`SECTOR_BIT]; // [RQ3] [RQ4] [RQ5]
      t.loc      = addr[7:0]; // [RQ4]
      t.via_port = 1'b0;
      // ports live only in sector 0; sector 1 low half is unused
      if (!addr[`SECTOR_BIT]) begin
         case (addr[7:0])
            `OFS_PORT_0: begin
               t.sector   = 1'b0; // [RQ10]
               t.loc      = s.pointer_0; // [RQ9]
               t.via_port = 1'b1;
            end
            `OFS_PORT_1: begin
               t.sector   = s.pointer_1_sector[0]; // [RQ1] [RQ2] [RQ14]
               t.loc      = s.pointer_1_low; // [RQ2] [RQ9] [RQ11]
               t.via_port = 1'b1;
            end
            `OFS_PORT_2: begin
               t.sector   = s.pointer_2_sector[0]; // [RQ1] [RQ2] [RQ14]
               t.loc      = s.pointer_2_low; // [RQ2] [RQ9] [RQ11]
               t.via_port = 1'b1;
            end
            default: begin
               t.via_port = 1'b0;
            end
         endcase
      end
      resolve = t;
   endfunction : resolve

   // value seen by a read of a physical target
   function automatic logic [7:0] read_target(
      input state_type  s,
      input target_type t
   );
      logic [7:0] v;
      v = `READ_ZERO;
      if (t.loc[`GP_SEL_BIT]) begin
         v = s.ram[gp_index(t.sector, t.loc)]; // [RQ6] [RQ13]
      end else if (!t.sector) begin
         case (t.loc)
            `OFS_POINTER_0:     v = s.pointer_0;
            `OFS_POINTER_1_LOW: v = s.pointer_1_low;
            `OFS_POINTER_1_SEC: v = s.pointer_1_sector;
            `OFS_POINTER_2_LOW: v = s.pointer_2_low;
            `OFS_POINTER_2_SEC: v = s.pointer_2_sector;
            `OFS_LAST_LOC:      v = s.last_loc;
            `OFS_LAST_SECTOR:   v = s.last_sector;
            // ports hold nothing, unused locations read zero
            default:            v = `READ_ZERO; // [RQ8] [RQ12]
         endcase
      end
      read_target = v;
   endfunction : read_target

   // new byte after a plain write or a bit operation
   function automatic logic [7:0] modify(
      input logic [7:0]   old,
      input write_op_type op,
      input logic [2:0]   bit_sel,
      input logic [7:0]   wdata
   );
      logic [7:0] v;
      v = old;
      case (op)
         op_write:     v = wdata;
         op_set_bit:   v[bit_sel] = 1'b1; // [RQ6]
         op_clear_bit: v[bit_sel] = 1'b0; // [RQ6]
         default:      v = old;
      endcase
      modify = v;
   endfunction : modify

   // ==========================================================
   // next state
   target_type tgt;
   logic [7:0] cur;
   logic [7:0] nv;

   always_comb begin
      state_next = state_reg;
      tgt        = resolve(state_reg, req.addr);
      cur        = read_target(state_reg, tgt);
      nv         = modify(cur, req.op, req.bit_sel, req.wdata);

      // data stand only in the cycle after the read strobe
      state_next.rd_data = `READ_ZERO;
      if (req.rd) begin
         state_next.rd_data = cur; // [RQ9]
      end

      if (req.wr) begin
         if (tgt.loc[`GP_SEL_BIT]) begin
            state_next.ram[gp_index(tgt.sector, tgt.loc)] = nv; // [RQ6]
         end else if (!tgt.sector && !is_port(tgt.loc)) begin
            // a port aimed at itself or another port is a no-op
            case (tgt.loc)
               `OFS_POINTER_0:     state_next.pointer_0 = nv;
               `OFS_POINTER_1_LOW: state_next.pointer_1_low = nv;
               `OFS_POINTER_1_SEC: state_next.pointer_1_sector = nv;
               `OFS_POINTER_2_LOW: state_next.pointer_2_low = nv;
               `OFS_POINTER_2_SEC: state_next.pointer_2_sector = nv;
               // last_loc, last_sector are read-only
               default: begin
                  state_next.last_loc = state_next.last_loc; // [RQ7]
               end
            endcase
         end
      end

      // record where the latest port access landed
      if ((req.wr || req.rd) && tgt.via_port) begin
         state_next.last_loc    = tgt.loc;
         state_next.last_sector = {7'b000_0000, tgt.sector};
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg.ram              <= '0;
         state_reg.pointer_0        <= `POINTER_RESET;
         state_reg.pointer_1_low    <= `POINTER_RESET;
         state_reg.pointer_1_sector <= `POINTER_RESET;
         state_reg.pointer_2_low    <= `POINTER_RESET;
         state_reg.pointer_2_sector <= `POINTER_RESET;
         state_reg.last_loc         <= `READ_ZERO;
         state_reg.last_sector      <= `READ_ZERO;
         state_reg.rd_data          <= `READ_ZERO;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data     = state_reg.rd_data;
   assign last_loc    = state_reg.last_loc;
   assign last_sector = state_reg.last_sector[0];

endmodule : sector_mem
`default_nettype wire

// File: bench/sector_mem_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sector_mem_assertions (
   input wire logic                        sys_clk,
   input wire logic                        rst_n,
   input wire sector_mem_pkg::mem_req_type req,
   input wire logic [7:0]                  rd_data,
   input wire logic [7:0]                  last_loc,
   input wire logic                        last_sector
);
   import sector_mem_pkg::*;
   logic port_acc;
   assign port_acc = (req.wr || req.rd)
      && (req.addr inside {9'h000, 9'h002, 9'h00C});
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ======================================================
   // properties
   property p_idle_zero; !req.rd |=> rd_data == 8'h00; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("rd idle");
   property p_unused;
      req.rd && req.addr inside {[9'h005:9'h00B]} |=> rd_data == 8'h00;
   endproperty
   a_unused: assert property (p_unused) else $error("unused");
   property p_sec1_low;
      req.rd && req.addr[8] && !req.addr[7] |=> rd_data == 8'h00;
   endproperty
   a_sec1_low: assert property (p_sec1_low) else $error("sec1");
   // a read right behind a write shows the new byte
   property p_ram_rw;
      req.rd && req.addr[7] && $past(req.wr) && $past(req.op) == op_write
         && $past(req.addr) == req.addr |=> rd_data == $past(req.wdata, 2);
   endproperty
   a_ram_rw: assert property (p_ram_rw) else $error("ram rw");
   property p_ro; req.rd && req.addr == 9'h060 |=> rd_data == last_loc;
   endproperty
   a_ro: assert property (p_ro) else $error("ro read");
   property p_hold; !port_acc |=> $stable({last_loc, last_sector});
   endproperty
   a_hold: assert property (p_hold) else $error("status moved");
   property p_port0; port_acc && req.addr == 9'h000 |=> !last_sector;
   endproperty
   a_port0: assert property (p_port0) else $error("port0 sector");
   property p_p1_loc;
      req.rd && req.addr == 9'h002
         && $past(req.wr && req.addr == 9'h003 && req.op == op_write)
         |=> last_loc == $past(req.wdata, 2);
   endproperty
   a_p1_loc: assert property (p_p1_loc) else $error("port1 loc");
   c_port1: cover property (req.rd && req.addr == 9'h002);
   c_ext: cover property (req.wr && req.addr[8]);
   c_ro: cover property (req.rd && req.addr == 9'h060);
endmodule : sector_mem_assertions
bind sector_mem sector_mem_assertions chk_i (.sys_clk(sys_clk),
   .rst_n(rst_n), .req(req), .rd_data(rd_data), .last_loc(last_loc),
   .last_sector(last_sector));
`default_nettype wire

// File: bench/test_data_memory_sector_addressing.sv
`timescale 1ns/10ps
`default_nettype none
module test_data_memory_sector_addressing;
   import sector_mem_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   mem_req_type req = '0;
   logic [7:0]  rd_data;
   logic [7:0]  last_loc;
   logic        last_sector;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cyc = 0;
   sector_mem dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
      .rd_data(rd_data), .last_loc(last_loc), .last_sector(last_sector));
   always #10 sys_clk = ~sys_clk;
   // ======================================================
   // helpers
   task automatic conclude;
      if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   // one request per edge; the next call overwrites, so no gap is forced
   task automatic op(logic [8:0] a, logic [7:0] d, logic w, logic r,
                     write_op_type o = op_write, logic [2:0] b = 3'h0);
      @(posedge sys_clk);
      req <= '{a, d, w, r, o, b};
   endtask : op
   task automatic wr(logic [8:0] a, logic [7:0] d);
      op(a, d, 1'b1, 1'b0);
   endtask : wr
   task automatic rd(logic [8:0] a, logic [7:0] e);
      op(a, 8'h00, 1'b0, 1'b1);
      op(9'h000, 8'h00, 1'b0, 1'b0);
      #1 chk("rd_data", e, rd_data);
   endtask : rd
   // ======================================================
   // scenarios
   task automatic t_reset;
      rd(9'h001, 8'h00);
      rd(9'h00E, 8'h00);
   endtask : t_reset
   task automatic t_direct;
      wr(9'h180, 8'hA5);
      wr(9'h080, 8'h5A);
      rd(9'h080, 8'h5A);
      rd(9'h180, 8'hA5);
      op(9'h180, 8'h00, 1'b1, 1'b0, op_set_bit, 3'h1);
      rd(9'h180, 8'hA7);
      op(9'h180, 8'hFF, 1'b1, 1'b0, op_clear_bit, 3'h7);
      rd(9'h180, 8'h27);
   endtask : t_direct
   task automatic t_ports;
      wr(9'h00E, 8'h03);
      wr(9'h00D, 8'h81);
      wr(9'h00C, 8'h3C);
      rd(9'h181, 8'h3C);
      chk("last_loc", 8'h81, last_loc);
      chk("last_sector", 8'h01, {7'h00, last_sector});
      wr(9'h004, 8'h01);
      wr(9'h003, 8'h80);
      rd(9'h002, 8'h27);
   endtask : t_ports
   task automatic t_protect;
      wr(9'h060, 8'hFF);
      rd(9'h060, 8'h80);
      wr(9'h061, 8'h00);
      rd(9'h061, 8'h01);
      wr(9'h005, 8'h55);
      rd(9'h005, 8'h00);
      wr(9'h105, 8'h55);
      rd(9'h105, 8'h00);
   endtask : t_protect
   task automatic t_port0;
      wr(9'h001, 8'h80);
      rd(9'h000, 8'h5A);
      chk("last_sector", 8'h00, {7'h00, last_sector});
      wr(9'h001, 8'h00);
      wr(9'h000, 8'h77);
      rd(9'h000, 8'h00);
      rd(9'h001, 8'h00);
   endtask : t_port0
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_direct();
      t_ports();
      t_protect();
      t_port0();
      conclude();
   end
endmodule : test_data_memory_sector_addressing
`default_nettype wire
